// ===== rtl/tsi_front.sv
`timescale 1ns/1ps
`default_nettype none
`include "tsi_map.svh"
module tsi_front
    import tsi_pkg::*;
(
    input wire logic mclk, // 40 MHz system clock
    input wire logic rstn, // async reset, active low
    input wire logic ce, // clock enable
    input wire logic ser_clk, // 16.384 MHz serial clock pin
    input wire logic [7:0] serial_in_streams, // serial inputs
    output logic [7:0] serial_out_streams, // serial outputs
    output logic [7:0] serial_out_oe, // output drive enables
    input wire logic out_drive_en, // serial output enable
    input wire logic frame_pulse_in, // frame sync pin
    input wire logic frame_eval_or_align_clock, // eval or align clock
    input wire logic wide_pulse_select, // 1 wide pulse mode
    input wire logic [31:0] in_frame_offset, // 4 bits per stream
    output logic gci_format, // sync idles low
    output logic [10:0] frame_eval_offset, // measured offset
    output logic frame_eval_valid, // offset captured
    input wire logic port_mux_select, // 1 multiplexed host bus
    input wire logic mux_rd_wr_style, // 1 separate read/write strobes
    input wire logic chip_sel_n, // host chip select
    input wire logic strobe_or_read, // data strobe or read
    input wire logic rw_or_write, // direction or write strobe
    input wire logic addr_strobe, // address latch strobe
    input wire logic [1:0] host_page, // upper memory index
    input wire logic [7:0] host_addr_lines, // address lines
    input wire logic [7:0] low_addr_data_in, // low bus in
    output logic [7:0] low_addr_data_out, // low bus out
    output logic [7:0] low_addr_data_oe, // low bus enable
    input wire logic [7:0] high_data_in, // high bus in
    output logic [7:0] high_data_out, // high bus out
    output logic [7:0] high_data_oe // high bus enable
);
    logic rst_q1; // reset stage one
    logic rst_s; // synchronised reset
    logic [`TSI_PIN_W-1:0] pin_s; // synchronised pins
    logic sclk_s, fp_s, fe_s, cs_n_s, strb_s, rw_s, as_s, mux_s, wide_s;
    logic [7:0] rx_s, haddr_s, ad_s, hd_s; // synced buses
    logic sclk_prev, al_prev; // edge history
    logic sclk_rise, sclk_d, align_rise; // ticks
    logic bit_start, chan_start; // slot events
    logic [10:0] fcnt; // serial clocks into frame
    logic bank; // data memory half being written
    logic fp_prev, fp_tick, idle_lvl, frame_start; // sync tracking
    logic [3:0] run; // sync level run length
    logic fe_prev; // eval pin history
    logic [63:0] byte_all; // received bytes
    logic [55:0] ch_all; // received channel numbers
    logic [7:0] pend; // bytes waiting
    logic wr_go; // data memory write
    logic [2:0] wr_sel; // stream being written
    logic seq_busy, p1_v, p2_v, p2_hiz; // fetch pipeline
    logic [3:0] seq_step; // fetch step
    logic [6:0] seq_ch; // channel being fetched
    logic [2:0] p1_s, p2_s; // stream per stage
    logic [7:0] pre_byte [8]; // bytes for next channel
    logic [7:0] pre_hiz; // float flags for next channel
    logic [`TSI_CM_DW-1:0] cm_q; // connection word
    logic [7:0] dm_q; // switched byte
    logic [`TSI_CM_AW-1:0] cm_raddr, cm_waddr, clr_idx, hp_idx;
    logic [`TSI_CM_DW-1:0] cm_wdata; // connection write word
    logic cm_we, hp_we, clr_busy; // connection writes
    tsi_hp_state_t hp_state; // host access state
    logic act, rd_req, rd_l, rd_cap; // host access terms
    logic [7:0] mux_addr; // latched multiplexed address
    logic [`TSI_CM_DW-1:0] host_rdata; // read word
    ////////////////////////////////////////////////////////////
    // reset released through two flops
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_q1 <= 1'b0;
            rst_s <= 1'b0;
        end
        else
        begin
            rst_q1 <= 1'b1;
            rst_s <= rst_q1;
        end
    end
    // pins but host_page, mux_rd_wr_style, out_drive_en and in_frame_offset pass two flops; chip select and frame sync idle high
    tsi_sync #(.W(`TSI_PIN_W), .INIT(`TSI_PIN_INIT)) u_sync (
        .mclk(mclk),
        .rst_n(rst_s),
        .ce(ce),
        .d({ser_clk, frame_pulse_in, frame_eval_or_align_clock, serial_in_streams,
            chip_sel_n, strobe_or_read, rw_or_write, addr_strobe, host_addr_lines,
            low_addr_data_in, high_data_in, port_mux_select, wide_pulse_select}),
        .q(pin_s)
    );
    assign {sclk_s, fp_s, fe_s, rx_s, cs_n_s, strb_s, rw_s, as_s, haddr_s, ad_s, hd_s,
            mux_s, wide_s} = pin_s;
    ////////////////////////////////////////////////////////////
    // edge history of serial and align clocks
    always_ff @(posedge mclk or negedge rst_s)
    begin
        if (!rst_s)
        begin
            sclk_prev <= 1'b0;
            al_prev <= 1'b0;
            sclk_d <= 1'b0;
        end
        else if (ce)
        begin
            sclk_prev <= sclk_s;
            al_prev <= fe_s;
            sclk_d <= sclk_rise;
        end
    end
    assign sclk_rise = ce && sclk_s && !sclk_prev;
    assign align_rise = ce && fe_s && !al_prev;
    // counter already moved when sclk_d fires; a bit is two clocks
    assign bit_start = ce && sclk_d && !fcnt[0];
    assign chan_start = bit_start && fcnt[3:0] == `TSI_CHAN_ZERO;
    // sync sampled on align clock in wide mode, else on serial clock
    assign fp_tick = wide_s ? align_rise : sclk_rise;
    always_comb
    begin
        if (wide_s)
            frame_start = align_rise && fp_prev && !fp_s;
        else
            frame_start = sclk_rise && fp_prev == idle_lvl && fp_s != idle_lvl;
    end
    assign gci_format = !idle_lvl;
    ////////////////////////////////////////////////////////////
    // idle level learned from long runs outside wide mode, pulse is the other level
    always_ff @(posedge mclk or negedge rst_s)
    begin
        if (!rst_s)
        begin
            fp_prev <= 1'b1;
            run <= 4'h0;
            idle_lvl <= 1'b1;
        end
        else if (fp_tick)
        begin
            fp_prev <= fp_s;
            if (fp_s != fp_prev)
                run <= 4'h0;
            else if (run != `TSI_IDLE_RUN)
                run <= run + 4'h1;
            else if (!wide_s)
                idle_lvl <= fp_s;
        end
    end
    ////////////////////////////////////////////////////////////
    // frame position, 128 channels of 16 serial clocks
    always_ff @(posedge mclk or negedge rst_s)
    begin
        if (!rst_s)
        begin
            fcnt <= `TSI_FCNT_ZERO;
            bank <= 1'b0;
        end
        else if (frame_start)
        begin
            fcnt <= `TSI_FCNT_ZERO;
            bank <= !bank;
        end
        else if (sclk_rise)
            fcnt <= fcnt + 11'h001;
    end
    ////////////////////////////////////////////////////////////
    // frame offset measurement on the eval pin
    always_ff @(posedge mclk or negedge rst_s)
    begin
        if (!rst_s)
        begin
            fe_prev <= 1'b0;
            frame_eval_offset <= `TSI_FCNT_ZERO;
            frame_eval_valid <= 1'b0;
        end
        else if (ce && !wide_s)
        begin
            if (sclk_rise)
                fe_prev <= fe_s;
            if (frame_start)
                frame_eval_valid <= 1'b0;
            else if (sclk_rise && fe_prev && !fe_s && !frame_eval_valid)
            begin
                frame_eval_offset <= fcnt;
                frame_eval_valid <= 1'b1;
            end
        end
    end
    ////////////////////////////////////////////////////////////
    // per stream receive and transmit
    for (genvar s = 0; s < `TSI_NSTREAM; s++)
    begin : g_str
        logic [10:0] loc; // position after stream offset
        logic [7:0] rx_sh, rx_byte, tx_sh; // shifters
        logic [6:0] rx_ch; // channel of rx_byte
        logic done; // byte complete
        assign loc = fcnt - {7'h00, in_frame_offset[s*`TSI_OFF_W +: `TSI_OFF_W]};
        assign done = ce && sclk_d && loc[0] && loc[3:1] == `TSI_BIT_LAST;
        assign byte_all[s*8 +: 8] = rx_byte;
        assign ch_all[s*7 +: 7] = rx_ch;
        assign serial_out_streams[s] = tx_sh[7];
        // sample mid bit, msb first
        always_ff @(posedge mclk or negedge rst_s)
        begin
            if (!rst_s)
            begin
                rx_sh <= 8'h00;
                rx_byte <= 8'h00;
                rx_ch <= 7'h00;
            end
            else if (ce && sclk_d && loc[0])
            begin
                rx_sh <= {rx_sh[6:0], rx_s[s]};
                if (done)
                begin
                    rx_byte <= {rx_sh[6:0], rx_s[s]};
                    rx_ch <= loc[10:4];
                end
            end
        end
        // new byte wins over the write grant
        always_ff @(posedge mclk or negedge rst_s)
        begin
            if (!rst_s)
                pend[s] <= 1'b0;
            else if (done)
                pend[s] <= 1'b1;
            else if (ce && wr_go && wr_sel == 3'(s))
                pend[s] <= 1'b0;
        end
        // load at channel start, shift at each bit start
        always_ff @(posedge mclk or negedge rst_s)
        begin
            if (!rst_s)
            begin
                tx_sh <= 8'h00;
                serial_out_oe[s] <= 1'b0;
            end
            else if (ce)
            begin
                if (chan_start)
                begin
                    tx_sh <= pre_byte[s];
                    serial_out_oe[s] <= out_drive_en && !pre_hiz[s];
                end
                else if (bit_start)
                    tx_sh <= {tx_sh[6:0], 1'b0};
                if (!out_drive_en)
                    serial_out_oe[s] <= 1'b0;
            end
        end
    end
    ////////////////////////////////////////////////////////////
    // lowest waiting stream gets the data memory write
    always_comb
    begin
        wr_go = 1'b0;
        wr_sel = 3'h0;
        for (int i = `TSI_NSTREAM - 1; i >= 0; i--)
        begin
            if (pend[i])
            begin
                wr_go = 1'b1;
                wr_sel = 3'(i);
            end
        end
    end
    tsi_ram #(.AW(`TSI_DM_AW), .DW(8)) u_dmem (
        .mclk(mclk),
        .ce(ce),
        .we(wr_go),
        .waddr({bank, wr_sel, ch_all[wr_sel*7 +: 7]}),
        .wdata(byte_all[wr_sel*8 +: 8]),
        .raddr({cm_q[`TSI_CM_CONST] ? !bank : bank, cm_q[9:0]}),
        .q(dm_q)
    );
    ////////////////////////////////////////////////////////////
    // fetch sequencer, eight streams for the coming channel
    always_ff @(posedge mclk or negedge rst_s)
    begin
        if (!rst_s)
        begin
            seq_busy <= 1'b0;
            seq_step <= 4'h0;
            seq_ch <= 7'h00;
        end
        else if (chan_start)
        begin
            seq_busy <= 1'b1;
            seq_step <= 4'h0;
            seq_ch <= fcnt[10:4] + 7'h01;
        end
        else if (ce && seq_busy)
        begin
            seq_busy <= seq_step != `TSI_SEQ_LAST;
            seq_step <= seq_step + 4'h1;
        end
    end
    // connection word, then source byte, then park it
    always_ff @(posedge mclk or negedge rst_s)
    begin
        if (!rst_s)
        begin
            {p1_v, p2_v, p2_hiz, p1_s, p2_s} <= 9'h000;
            pre_hiz <= 8'hff;
            for (int i = 0; i < `TSI_NSTREAM; i++)
                pre_byte[i] <= 8'h00;
        end
        else if (ce)
        begin
            p1_v <= seq_busy && seq_step < `TSI_SEQ_READS;
            p1_s <= seq_step[2:0];
            p2_v <= p1_v;
            p2_s <= p1_s;
            p2_hiz <= cm_q[`TSI_CM_HIZ];
            if (p2_v)
            begin
                pre_byte[p2_s] <= dm_q;
                pre_hiz[p2_s] <= p2_hiz;
            end
        end
    end
    ////////////////////////////////////////////////////////////
    // connection memory, cleared to floating after reset
    assign cm_raddr = seq_busy ? {seq_step[2:0], seq_ch} : hp_idx;
    assign cm_we = clr_busy || hp_we;
    assign cm_waddr = clr_busy ? clr_idx : hp_idx;
    assign cm_wdata = clr_busy ? `TSI_CM_INIT : {hd_s[3:0], ad_s};
    tsi_ram #(.AW(`TSI_CM_AW), .DW(`TSI_CM_DW)) u_cmem (
        .mclk(mclk),
        .ce(ce),
        .we(cm_we),
        .waddr(cm_waddr),
        .wdata(cm_wdata),
        .raddr(cm_raddr),
        .q(cm_q)
    );
    always_ff @(posedge mclk or negedge rst_s)
    begin
        if (!rst_s)
        begin
            clr_busy <= 1'b1;
            clr_idx <= 10'h000;
        end
        else if (ce && clr_busy)
        begin
            clr_busy <= clr_idx != `TSI_CLR_LAST;
            clr_idx <= clr_idx + 10'h001;
        end
    end
    ////////////////////////////////////////////////////////////
    // host strobe decode by bus style
    always_comb
    begin
        if (!mux_s)
            act = !cs_n_s && !strb_s;
        else if (mux_rd_wr_style)
            act = !cs_n_s && (!strb_s || !rw_s);
        else
            act = !cs_n_s && strb_s;
        rd_req = (mux_s && mux_rd_wr_style) ? !strb_s : rw_s;
    end
    assign hp_idx = {host_page, mux_s ? mux_addr : haddr_s};
    assign hp_we = ce && hp_state == TSI_HP_WRITE;
    // low bus followed while the address strobe is high, held once it falls
    always_ff @(posedge mclk or negedge rst_s)
    begin
        if (!rst_s)
            mux_addr <= 8'h00;
        else if (ce && mux_s && as_s)
            mux_addr <= ad_s;
    end
    ////////////////////////////////////////////////////////////
    // host access state machine
    always_ff @(posedge mclk or negedge rst_s)
    begin
        if (!rst_s)
        begin
            hp_state <= TSI_HP_IDLE;
            rd_l <= 1'b0;
            rd_cap <= 1'b0;
            host_rdata <= 12'h000;
        end
        else if (ce)
        begin
            rd_cap <= 1'b0;
            if (rd_cap)
                host_rdata <= cm_q;
            unique case (hp_state)
                TSI_HP_IDLE:
                    if (act && !clr_busy)
                    begin
                        rd_l <= rd_req;
                        hp_state <= rd_req ? TSI_HP_READ : TSI_HP_WRITE;
                    end
                TSI_HP_READ:
                    if (!seq_busy)
                    begin
                        rd_cap <= 1'b1;
                        hp_state <= TSI_HP_HOLD;
                    end
                TSI_HP_WRITE:
                    hp_state <= TSI_HP_HOLD;
                TSI_HP_HOLD:
                    if (!act)
                        hp_state <= TSI_HP_IDLE;
            endcase
        end
    end
    // data bus driven only while a read strobe stands
    always_ff @(posedge mclk or negedge rst_s)
    begin
        if (!rst_s)
        begin
            low_addr_data_oe <= 8'h00;
            high_data_oe <= 8'h00;
            low_addr_data_out <= 8'h00;
            high_data_out <= 8'h00;
        end
        else if (ce)
        begin
            low_addr_data_oe <= {8{hp_state == TSI_HP_HOLD && rd_l && act && !rd_cap}};
            high_data_oe <= {8{hp_state == TSI_HP_HOLD && rd_l && act && !rd_cap}};
            low_addr_data_out <= host_rdata[7:0];
            high_data_out <= {4'h0, host_rdata[11:8]};
        end
    end
    ////////////////////////////////////////////////////////////
    // checks
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_s);
    AST_RESET_HIZ: assert property (@(posedge mclk) disable iff (1'b0)
        !rst_s |-> serial_out_oe == 8'h00 && low_addr_data_oe == 8'h00)
        else $error("outputs driven during reset");
    AST_FRAME_WRAP: assert property (
        sclk_rise && !frame_start && fcnt == `TSI_FRAME_LAST |=> fcnt == `TSI_FCNT_ZERO)
        else $error("frame counter did not wrap");
    AST_BIT_TWO_SCLK: assert property (
        $changed(serial_out_streams) |-> $past(bit_start))
        else $error("serial output changed outside a bit start");
    AST_STD_SYNC: assert property (
        !wide_s && sclk_rise && fp_prev == idle_lvl && fp_s != idle_lvl
        |=> fcnt == `TSI_FCNT_ZERO && bank != $past(bank))
        else $error("standard frame pulse not taken");
    AST_WIDE_SYNC: assert property (
        wide_s && align_rise && fp_prev && !fp_s
        |=> fcnt == `TSI_FCNT_ZERO ##1 fcnt != `TSI_FRAME_LAST)
        else $error("wide frame pulse not taken");
    AST_HIZ_CHAN: assert property (
        chan_start && pre_hiz[0] |=> !serial_out_oe[0])
        else $error("floated channel was driven");
    AST_SEQ_BOUND: assert property (
        chan_start |=> seq_busy && seq_step == 4'h0
        ##9 seq_busy && seq_step == `TSI_SEQ_LAST ##1 !seq_busy)
        else $error("fetch did not finish in ten cycles");
    AST_NONMUX_WR: assert property (
        ce && hp_state == TSI_HP_IDLE && act && !rd_req && !clr_busy && !mux_s
        |=> cm_we && cm_waddr[7:0] == $past(haddr_s))
        else $error("write not taken at address lines");
    AST_DS_HIGH: assert property (
        ce && mux_s && !mux_rd_wr_style && hp_state == TSI_HP_IDLE && !cs_n_s && strb_s
        && !clr_busy |=> hp_state != TSI_HP_IDLE)
        else $error("high data strobe ignored");
    AST_RD_DRIVE: assert property (
        low_addr_data_oe != 8'h00 |-> $past(act) && rd_l)
        else $error("bus driven without read strobe");
    COV_FRAME: cover property (frame_start ##[1:1000] chan_start);
    COV_WRITE: cover property (hp_state == TSI_HP_WRITE);
    COV_READ: cover property (low_addr_data_oe == 8'hff);
endmodule : tsi_front
`default_nettype wire

// ===== rtl/tsi_map.svh
`ifndef TSI_MAP_SVH
`define TSI_MAP_SVH
`define TSI_NSTREAM 8
`define TSI_PIN_W 41
`define TSI_PIN_INIT 41'h08020000000
`define TSI_FRAME_LAST 11'h7ff
`define TSI_FCNT_ZERO 11'h000
`define TSI_BIT_LAST 3'h7
`define TSI_CHAN_ZERO 4'h0
`define TSI_IDLE_RUN 4'h8
`define TSI_SEQ_READS 4'h8
`define TSI_SEQ_LAST 4'h9
`define TSI_CM_AW 10
`define TSI_CM_DW 12
`define TSI_DM_AW 11
`define TSI_CM_CONST 10
`define TSI_CM_HIZ 11
`define TSI_CM_INIT 12'h800
`define TSI_CLR_LAST 10'h3ff
`define TSI_OFF_W 4
`define TSI_MCLK_NS 25
`define TSI_RST_MIN_NS 100
`define TSI_RST_MIN_CYC ((`TSI_RST_MIN_NS + `TSI_MCLK_NS - 1) / `TSI_MCLK_NS)
`endif

// ===== rtl/tsi_pkg.sv
package tsi_pkg;
    // host port access sequence
    typedef enum logic [1:0] {
        TSI_HP_IDLE = 2'b00,
        TSI_HP_READ = 2'b01,
        TSI_HP_WRITE = 2'b10,
        TSI_HP_HOLD = 2'b11
    } tsi_hp_state_t;
endpackage : tsi_pkg

// ===== rtl/tsi_ram.sv
`timescale 1ns/1ps
`default_nettype none
module tsi_ram #(
    parameter int AW = 10, // address width
    parameter int DW = 12 // word width
)
(
    input wire logic mclk, // system clock
    input wire logic ce, // clock enable
    input wire logic we, // write strobe
    input wire logic [AW-1:0] waddr, // write address
    input wire logic [DW-1:0] wdata, // write word
    input wire logic [AW-1:0] raddr, // read address
    output logic [DW-1:0] q // registered read word
);
    logic [DW-1:0] mem [2**AW]; // storage
    ////////////////////////////////////////////////////////////
    // one write and one registered read per cycle
    always_ff @(posedge mclk)
    begin
        if (ce)
        begin
            if (we)
                mem[waddr] <= wdata;
            q <= mem[raddr];
        end
    end
endmodule : tsi_ram
`default_nettype wire

// ===== rtl/tsi_sync.sv
`timescale 1ns/1ps
`default_nettype none
module tsi_sync #(
    parameter int W = 1, // bit count
    parameter logic [W-1:0] INIT = '0 // idle level under reset
)
(
    input wire logic mclk, // system clock
    input wire logic rst_n, // synchronised reset
    input wire logic ce, // clock enable
    input wire logic [W-1:0] d, // asynchronous pins
    output logic [W-1:0] q // synchronised copies
);
    logic [W-1:0] meta; // first stage, read only by q
    ////////////////////////////////////////////////////////////
    // two stages, frozen while ce is low
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta <= INIT;
            q <= INIT;
        end
        else if (ce)
        begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : tsi_sync
`default_nettype wire

// ===== test/tsi_far_end.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
// far end of the serial streams: clock, frame sync and data
module tsi_far_end
(
    output logic ser_clk, // 16.384 MHz serial clock
    output logic frame_pulse, // frame sync, low pulse
    output logic align_clk, // 4.096 MHz helper clock
    output logic [7:0] rx // serial data into the switch
);
    logic [10:0] cnt = 11'h000; // serial clock count within a frame
    // free running serial clock
    initial
    begin
        ser_clk = 1'b0;
        forever #30.518 ser_clk = ~ser_clk;
    end
    // far end changes its lines on the falling serial clock
    always @(negedge ser_clk)
    begin
        cnt <= cnt + 11'h001;
    end
    // negative frame pulse, four serial clocks so a helper clock rise sees it low
    assign frame_pulse = (cnt < 11'h004) ? 1'b0 : 1'b1;
    // helper clock at a quarter of the serial clock
    assign align_clk = cnt[1];
    // one bit spans two serial clocks, pattern differs per stream
    assign rx = {8{cnt[1]}} ^ {cnt[8:2], cnt[1]};
endmodule : tsi_far_end
`default_nettype wire

// ===== test/tsi_front_bench.sv
`timescale 1ns/1ps
`default_nettype none
module tsi_front_bench;
    logic mclk, rstn, cs_n, strb, rw, mux, as, wide, sty; // bench driven controls
    logic [1:0] page; // memory page
    logic [7:0] addr, lo, hi, tx, tx_oe, lo_o, lo_oe, hi_o, hi_oe; // buses
    logic sclk, fp, ac, gci, fev; // serial side
    logic [7:0] rx; // serial data in
    logic [10:0] feo; // measured offset
    logic [11:0] got; // read word
    int errors, checked, bad, on0, ev; // counters
    logic [21:0] rows [0:3] = '{22'h000012, 22'h3fffff, 22'h15a4a5, 22'h2817c3}; // {page,addr,word}
    ////////////////////////////////////////////////////////////////////
    tsi_far_end tsi_far_end_i (.ser_clk(sclk), .frame_pulse(fp), .align_clk(ac), .rx(rx));
    tsi_front tsi_front_i (.mclk(mclk), .rstn(rstn), .ce(1'b1), .ser_clk(sclk),
        .serial_in_streams(rx), .serial_out_streams(tx), .serial_out_oe(tx_oe),
        .out_drive_en(1'b1), .frame_pulse_in(fp), .frame_eval_or_align_clock(ac),
        .wide_pulse_select(wide), .in_frame_offset(32'h00000000), .gci_format(gci),
        .frame_eval_offset(feo), .frame_eval_valid(fev), .port_mux_select(mux),
        .mux_rd_wr_style(sty), .chip_sel_n(cs_n), .strobe_or_read(strb), .rw_or_write(rw),
        .addr_strobe(as), .host_page(page), .host_addr_lines(addr), .low_addr_data_in(lo),
        .low_addr_data_out(lo_o), .low_addr_data_oe(lo_oe), .high_data_in(hi),
        .high_data_out(hi_o), .high_data_oe(hi_oe));
    ////////////////////////////////////////////////////////////////////
    // 40 MHz system clock
    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // compare one word
    task automatic chk(input logic [11:0] g, input logic [11:0] e);
        checked++;
        if (g !== e)
        begin
            errors++;
            $display("Error t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // verdict
    task automatic test_done;
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : test_done
    // reset, check floating outputs, then wait out the memory clear
    task automatic rst_cycle;
        rstn <= 1'b0;
        repeat (8) @(posedge mclk);
        chk({4'h0, tx_oe}, 12'h000);
        chk({lo_oe, hi_oe[3:0]}, 12'h000);
        rstn <= 1'b1;
        repeat (1100) @(posedge mclk);
    endtask : rst_cycle
    // one host access; m selects multiplexed bus, sty its strobe style
    task automatic acc(input logic m, input logic [21:0] v, input logic wr);
        int n;
        n = 0;
        mux <= m;
        page <= v[21:20];
        addr <= v[19:12];
        as <= m;
        lo <= m ? v[19:12] : v[7:0];
        hi <= {4'h0, v[11:8]};
        rw <= ~wr;
        repeat (4) @(posedge mclk);
        as <= 1'b0;
        repeat (4) @(posedge mclk);
        cs_n <= 1'b0;
        strb <= m & (wr | ~sty);
        while (!wr && lo_oe !== 8'hff && n < 40)
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        got = {hi_o[3:0], lo_o};
        if (!wr)
            chk({hi_oe, hi_o[7:4]}, 12'hff0);
        repeat (8) @(posedge mclk);
        cs_n <= 1'b1;
        strb <= 1'b1;
        rw <= 1'b1;
        repeat (10) @(posedge mclk);
    endtask : acc
    // settle, then watch one frame; only streams 0, 2 and 5 hold driven entries
    task automatic watch_frame(output int nbad, output int non0, output int nev);
        nbad = 0;
        non0 = 0;
        nev = 0;
        repeat (12000) @(posedge mclk);
        repeat (5000)
        begin
            @(posedge mclk);
            #1;
            non0 += tx_oe[0];
            nev += fev;
            if ((tx_oe & 8'hda) != 8'h00 || (tx_oe[0] && tx[0] !== 1'b0))
                nbad++;
        end
        @(posedge mclk);
    endtask : watch_frame
    ////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        errors = 0;
        checked = 0;
        {rstn, cs_n, strb, rw, mux, as, page, addr, lo, hi} = 32'h7c000000;
        {wide, sty} = 2'b01;
        rst_cycle;
        foreach (rows[i])
        begin
            acc(1'b0, rows[i], 1'b1);
            acc(1'b0, rows[i], 1'b0);
            chk(got, rows[i][11:0]);
        end
        acc(1'b0, 22'h001000, 1'b0);
        chk(got, 12'h800);
        acc(1'b1, rows[2], 1'b0);
        chk(got, rows[2][11:0]);
        sty <= 1'b0;
        acc(1'b1, rows[3], 1'b0);
        chk(got, rows[3][11:0]);
        watch_frame(bad, on0, ev);
        chk(12'(bad), 12'h000);
        chk({11'h000, on0 != 0}, 12'h001);
        chk({11'h000, ev != 0}, 12'h001);
        chk({11'h000, gci}, 12'h000);
        wide <= 1'b1;
        watch_frame(bad, on0, ev);
        chk(12'(bad), 12'h000);
        chk({11'h000, on0 != 0}, 12'h001);
        wide <= 1'b0;
        rst_cycle;
        acc(1'b0, rows[1], 1'b0);
        chk(got, 12'h800);
        test_done;
    end
    // watchdog
    initial
    begin
        repeat (60000) @(posedge mclk);
        errors++;
        test_done;
    end
endmodule : tsi_front_bench
`default_nettype wire
